// ===== rtl/sdoc_pkg.sv
// Purpose: shared constants of the deserializer output control block
// Assumes: one serial bit cell lasts one reference clock period
// Notes:   frame is start 1, ten data bits lsb first, stop 0
package sdoc_pkg;
   localparam int WORD_W = 10;
   localparam int FRAME_W = 12;
   localparam int PHASE_W = 4;
   localparam logic [3:0] PHASE_FIRST = 4'h0;
   localparam logic [3:0] PHASE_HALF = 4'h6;
   localparam logic [3:0] PHASE_LAST = 4'hB;
   localparam int GOOD_W = 3;
   localparam logic [2:0] LOCK_WORDS = 3'h4;
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] ADDR_WORD = 8'h10;
   localparam int CTRL_W = 2;
   localparam int CTRL_SLEEP = 0;
   localparam int CTRL_OFF = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam int IRQ_W = 3;
   localparam int IRQ_LOCK = 0;
   localparam int IRQ_LOST = 1;
   localparam int IRQ_FRAME = 2;
   localparam logic [2:0] IRQ_RESET = 3'h0;
   localparam int PIN_W = 6;
   localparam int PIN_REF = 0;
   localparam int PIN_SP = 1;
   localparam int PIN_SN = 2;
   localparam int PIN_SLEEP = 3;
   localparam int PIN_REN = 4;
   localparam int PIN_EDGE = 5;
   typedef enum logic [1:0] {
      SDOC_OFF,
      SDOC_HUNT,
      SDOC_LOCK
   } sdoc_state_t;
endpackage

// ===== rtl/sdoc_deserializer.sv
// Purpose: word alignment, lock and output control of a 10-bit deserializer
// Assumes: all pins arrive asynchronously and pass two flip-flops
// Notes:   output enables stand for the three-state pins
// Operation
// [R1] lock indicator goes low once the framing edge is found
// [R2] sleep request low stops recovery and floats all outputs
// [R3] edge select low strobes on falling, high on rising edge
// [R4] user logic captures words with the recovered clock only
// [R5] receive enable low floats data and recovered clock
// [R6] system supplies the local reference clock that paces recovery
// [R7] each word appears on ten data outputs, bit zero to nine
// [R8] while unlocked, data and recovered clock stay floating
// [R9] one complete ten-bit word per recovered clock period
`timescale 1ns/10ps
module sdoc_deserializer (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        serial_in_p,
   input  wire logic        serial_in_n,
   input  wire logic        pll_local_reference,
   input  wire logic        sleep_request_n,
   input  wire logic        receive_enable,
   input  wire logic        strobe_edge_select,
   output logic      [9:0]  parallel_word_out,
   output logic             parallel_word_oe,
   output logic             recovered_clk_out,
   output logic             recovered_clk_oe,
   output logic             lock_n_out,
   output logic             lock_n_oe,
   output logic             irq
);
   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] off);
      hit = (a == off);
   endfunction

   function automatic logic [sdoc_pkg::WORD_W-1:0] frame_word(
      input logic [sdoc_pkg::FRAME_W-1:0] f);
      frame_word = f[sdoc_pkg::WORD_W:1];
   endfunction

   logic [sdoc_pkg::PIN_W-1:0]   pin_s1;
   logic [sdoc_pkg::PIN_W-1:0]   pin_s2;
   logic                         ref_s3;
   sdoc_pkg::sdoc_state_t        state;
   sdoc_pkg::sdoc_state_t        next_state;
   logic [sdoc_pkg::PHASE_W-1:0] phase;
   logic [sdoc_pkg::PHASE_W-1:0] next_phase;
   logic [sdoc_pkg::FRAME_W-1:0] shift;
   logic [sdoc_pkg::FRAME_W-1:0] next_shift;
   logic                         line_bad;
   logic                         next_bad;
   logic [sdoc_pkg::GOOD_W-1:0]  good_cnt;
   logic [sdoc_pkg::WORD_W-1:0]  word_hold;
   logic [sdoc_pkg::WORD_W-1:0]  word_q;
   logic                         rclk_q;
   logic [sdoc_pkg::CTRL_W-1:0]  ctrl;
   logic [sdoc_pkg::IRQ_W-1:0]   irq_stat;
   logic [sdoc_pkg::IRQ_W-1:0]   irq_mask;
   logic [sdoc_pkg::IRQ_W-1:0]   irq_set;
   logic [sdoc_pkg::IRQ_W-1:0]   irq_clr;

   wire ref_s2 = pin_s2[sdoc_pkg::PIN_REF];
   wire sp = pin_s2[sdoc_pkg::PIN_SP];
   wire sn = pin_s2[sdoc_pkg::PIN_SN];
   wire ren = pin_s2[sdoc_pkg::PIN_REN];
   wire edge_rise = pin_s2[sdoc_pkg::PIN_EDGE];

   // [R2] sleep gate
   wire powered = pin_s2[sdoc_pkg::PIN_SLEEP] &
                  ~ctrl[sdoc_pkg::CTRL_SLEEP];
   // [R6] reference pacing
   // one rising reference edge stands for one bit cell of the pll
   wire bit_tick = powered & ref_s2 & ~ref_s3;
   wire locked = (state == sdoc_pkg::SDOC_LOCK);
   wire hunting = (state == sdoc_pkg::SDOC_HUNT);
   wire frame_end = bit_tick & (phase == sdoc_pkg::PHASE_LAST);
   wire frame_ok = next_shift[0] & ~next_shift[sdoc_pkg::FRAME_W-1]
                   & ~next_bad;
   wire frame_good = frame_end & frame_ok;
   wire frame_fail = frame_end & ~frame_ok;
   wire lock_done = frame_good & hunting &
                    (good_cnt == sdoc_pkg::LOCK_WORDS - 3'h1);
   wire lock_lost = frame_fail & locked;

   // apb decode
   wire setup = psel & ~penable;
   wire access = psel & penable;
   wire hit_ctrl = hit(paddr, sdoc_pkg::ADDR_CTRL);
   wire hit_stat = hit(paddr, sdoc_pkg::ADDR_STATUS);
   wire hit_irqs = hit(paddr, sdoc_pkg::ADDR_IRQ_STAT);
   wire hit_mask = hit(paddr, sdoc_pkg::ADDR_IRQ_MASK);
   wire hit_word = hit(paddr, sdoc_pkg::ADDR_WORD);
   wire mapped = hit_ctrl | hit_stat | hit_irqs | hit_mask | hit_word;
   wire wr_en = access & pwrite & mapped & ce;
   // status, lsb first: locked, hunting, phase tap, powered, enable, edge
   wire phase_tap = (phase[2:0] == 3'h0);
   wire [31:0] status_word = {26'h0000000, edge_rise, ren, powered,
                              phase_tap, hunting, locked};
   wire [31:0] rd_mux =
      hit_ctrl ? {30'h00000000, ctrl} :
      hit_stat ? status_word :
      hit_irqs ? {29'h00000000, irq_stat} :
      hit_mask ? {29'h00000000, irq_mask} :
      hit_word ? {22'h000000, word_hold} : 32'h00000000;

   // registers answer at once, so the bus never waits
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;

   // a line with both legs equal cannot carry a bit
   assign next_shift = {sp, shift[sdoc_pkg::FRAME_W-1:1]};
   assign next_bad = line_bad | (sp == sn);

   always_comb begin
      next_phase = phase;
      if (phase == sdoc_pkg::PHASE_LAST) begin
         // slip one bit per failed frame while searching
         if (hunting & ~frame_ok) begin
            next_phase = phase;
         end else begin
            next_phase = sdoc_pkg::PHASE_FIRST;
         end
      end else begin
         next_phase = phase + 4'h1;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         sdoc_pkg::SDOC_OFF: begin
            next_state = sdoc_pkg::SDOC_HUNT;
         end
         sdoc_pkg::SDOC_HUNT: begin
            if (lock_done) begin
               next_state = sdoc_pkg::SDOC_LOCK;
            end
         end
         sdoc_pkg::SDOC_LOCK: begin
            if (lock_lost) begin
               next_state = sdoc_pkg::SDOC_HUNT;
            end
         end
         default: begin
            next_state = sdoc_pkg::SDOC_OFF;
         end
      endcase
      if (!powered) begin
         next_state = sdoc_pkg::SDOC_OFF;
      end
   end

   assign irq_set = {frame_fail, lock_lost, lock_done};
   // write one to clear
   assign irq_clr = (wr_en & hit_irqs) ?
                    pwdata[sdoc_pkg::IRQ_W-1:0] : 3'h0;

   // one shared two-stage synchroniser keeps each bit beside its edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1 <= 6'h00;
         pin_s2 <= 6'h00;
         ref_s3 <= 1'b0;
      end else if (ce) begin
         pin_s1 <= {strobe_edge_select, receive_enable, sleep_request_n,
                    serial_in_n, serial_in_p, pll_local_reference};
         pin_s2 <= pin_s1;
         ref_s3 <= ref_s2;
      end
   end

   // [R1] lock search
   // limitation: the blind search takes any 0-then-1 pair as a frame
   // edge, so words with a 0-to-1 step inside can lock off by bits;
   // a link that sends such words must first send plain sync words
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= sdoc_pkg::SDOC_OFF;
      end else if (ce) begin
         state <= next_state;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // park on the last phase so the search tests the first bit
         phase <= sdoc_pkg::PHASE_LAST;
         shift <= 12'h000;
         line_bad <= 1'b0;
      end else if (ce) begin
         if (!powered) begin
            phase <= sdoc_pkg::PHASE_LAST;
            line_bad <= 1'b0;
         end else if (bit_tick) begin
            phase <= next_phase;
            shift <= next_shift;
            line_bad <= frame_end ? 1'b0 : next_bad;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         good_cnt <= 3'h0;
      end else if (ce) begin
         // only an unbroken run of good frames counts toward lock
         if (!powered | frame_fail) begin
            good_cnt <= 3'h0;
         end else if (frame_good & ~lock_done & hunting) begin
            good_cnt <= good_cnt + 3'h1;
         end else if (lock_done) begin
            good_cnt <= 3'h0;
         end
      end
   end

   // [R9] one word per recovered period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_hold <= 10'h000;
         rclk_q <= 1'b0;
      end else if (ce) begin
         if (frame_good) begin
            word_hold <= frame_word(next_shift);
         end
         // high over the first half of the frame, low over the second
         if (bit_tick) begin
            rclk_q <= (next_phase < sdoc_pkg::PHASE_HALF);
         end
      end
   end

   // [R3] data changes on the edge opposite the strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_q <= 10'h000;
      end else if (ce) begin
         if (frame_good & ~edge_rise) begin
            word_q <= frame_word(next_shift);
         end else if (bit_tick & edge_rise &
                      next_phase == sdoc_pkg::PHASE_HALF) begin
            word_q <= word_hold;
         end
      end
   end

   // [R7] bit i on output i
   assign parallel_word_out = word_q;
   assign recovered_clk_out = rclk_q;
   // [R5] [R8] float unless enabled and locked
   assign parallel_word_oe = powered & ren & locked &
                             ~ctrl[sdoc_pkg::CTRL_OFF];
   assign recovered_clk_oe = parallel_word_oe;
   // [R1] active-low lock, floating in sleep
   // the state leaves lock one edge after sleep; gating keeps the pin
   // from reading locked while it floats
   assign lock_n_out = ~(locked & powered);
   assign lock_n_oe = powered;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= sdoc_pkg::CTRL_RESET;
      end else if (wr_en & hit_ctrl) begin
         ctrl <= pwdata[sdoc_pkg::CTRL_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= sdoc_pkg::IRQ_RESET;
      end else if (wr_en & hit_mask) begin
         irq_mask <= pwdata[sdoc_pkg::IRQ_W-1:0];
      end
   end

   // a new event beats a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= sdoc_pkg::IRQ_RESET;
      end else if (ce) begin
         irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      end
   end

   // read data is taken in the setup cycle and stands through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (ce & setup) begin
         prdata <= rd_mux;
      end
   end

   assign irq = |(irq_stat & irq_mask);
endmodule

// ===== bench/sdoc_serializer_model.sv
// Purpose: remote serializer driving the serial link and reference
// Assumes: frame is start 1, ten bits lsb first, stop 0
// Notes:   corrupt makes the start bit legs equal
`timescale 1ns/10ps
module sdoc_serializer_model (
   output logic       ref_clk,
   output logic       sp,
   output logic       sn,
   input  wire logic [9:0] tx_word,
   input  wire logic  corrupt
);
   logic [11:0] frame;
   int          k;
   initial begin
      ref_clk = 1'b0;
      forever #40 ref_clk = ~ref_clk;
   end
   // frames run back to back, bits change away from the sampling edge
   initial begin
      sp = 1'b0;
      sn = 1'b1;
      forever begin
         frame = {1'b0, tx_word, 1'b1};
         for (k = 0; k < 12; k++) begin
            @(negedge ref_clk);
            sp <= frame[k];
            sn <= (corrupt && k == 0) ? frame[k] : ~frame[k];
         end
      end
   end
endmodule

// ===== bench/sdoc_deserializer_asserts.sv
// Purpose: pin level checks of the deserializer
// Assumes: async pins settle within five clocks
// Notes:   bound to every deserializer instance
`timescale 1ns/10ps
module sdoc_deserializer_asserts (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       sleep_request_n,
   input wire logic       receive_enable,
   input wire logic       strobe_edge_select,
   input wire logic [9:0] parallel_word_out,
   input wire logic       parallel_word_oe,
   input wire logic       recovered_clk_out,
   input wire logic       recovered_clk_oe,
   input wire logic       lock_n_out,
   input wire logic       lock_n_oe
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_float_unlocked: assert property (lock_n_out |-> !parallel_word_oe)
      else $error("word driven while unlocked");
   a_oe_pair: assert property (parallel_word_oe == recovered_clk_oe)
      else $error("enables differ");
   a_sleep_float: assert property ((!sleep_request_n) [*5] |->
      !lock_n_oe && !parallel_word_oe && lock_n_out)
      else $error("driving while asleep");
   a_disable_float: assert property ((!receive_enable) [*5] |->
      !parallel_word_oe) else $error("driving while disabled");
   a_lock_driven: assert property (!lock_n_out |-> lock_n_oe)
      else $error("lock not driven");
   a_fall_strobe: assert property ((!strobe_edge_select) [*4] ##0
      (!lock_n_out && $changed(parallel_word_out)) |->
      $rose(recovered_clk_out)) else $error("word moved off rise");
   a_rise_strobe: assert property (strobe_edge_select [*4] ##0
      (!lock_n_out && $changed(parallel_word_out)) |->
      $fell(recovered_clk_out)) else $error("word moved off fall");
   a_rclk_period: assert property ($rose(recovered_clk_out) |->
      (recovered_clk_out || lock_n_out) [*8]) else $error("short rclk");
endmodule
bind sdoc_deserializer sdoc_deserializer_asserts chk (
   .pclk(pclk), .presetn(presetn), .sleep_request_n(sleep_request_n),
   .receive_enable(receive_enable), .strobe_edge_select(strobe_edge_select),
   .parallel_word_out(parallel_word_out), .parallel_word_oe(parallel_word_oe),
   .recovered_clk_out(recovered_clk_out), .recovered_clk_oe(recovered_clk_oe),
   .lock_n_out(lock_n_out), .lock_n_oe(lock_n_oe));

// ===== bench/sdoc_deserializer_bench.sv
// Purpose: self-checking bench of the deserializer
// Assumes: serializer model supplies link and reference
// Notes:   pin words are taken on the recovered clock, the word register over apb
`timescale 1ns/10ps
module sdoc_deserializer_bench;
   logic        pclk, pready, pslverr, irq, sp, sn, rf, lk, lk_oe;
   logic        w_oe, rc, rc_oe, err, snap_rc;
   logic        ce = 1'b1;
   logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        sl_n = 1'b1, ren = 1'b1, es = 1'b0, corrupt = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   // a word with no 0-to-1 step can frame only at its true start bit
   logic [9:0]  word, got, snap, tx = 10'h3FF;
   int          bad_count = 0, num_checks = 0;
   sdoc_serializer_model peer (.ref_clk(rf), .sp(sp), .sn(sn), .tx_word(tx),
      .corrupt(corrupt));
   sdoc_deserializer uut (.pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_in_p(sp), .serial_in_n(sn), .pll_local_reference(rf),
      .sleep_request_n(sl_n), .receive_enable(ren), .strobe_edge_select(es),
      .parallel_word_out(word), .parallel_word_oe(w_oe),
      .recovered_clk_out(rc), .recovered_clk_oe(rc_oe), .lock_n_out(lk),
      .lock_n_oe(lk_oe), .irq(irq));
   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task check(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task hang(input string msg);
      check(1'b0, msg);
      stop_test();
   endtask
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (pready !== 1'b1) hang("apb hang");
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task wait_lock(input logic v);
      int n;
      for (n = 0; n < 8000 && lk !== v; n++)
         @(posedge pclk);
      if (lk !== v) hang("lock wait");
   endtask
   task grab;
      int n;
      logic p;
      p = rc;
      for (n = 0; n < 400; n++) begin
         @(posedge pclk);
         if (rc !== p && rc === es) break;
         p = rc;
      end
      if (n >= 400) hang("no strobe");
      got = word;
   endtask
   task t_regs;
      apb(1'b0, sdoc_pkg::ADDR_CTRL, 32'h0);
      check(q === 32'h0, "ctrl reset");
      apb(1'b1, sdoc_pkg::ADDR_IRQ_MASK, 32'h7);
      apb(1'b0, sdoc_pkg::ADDR_IRQ_MASK, 32'h0);
      check(q === 32'h7, "mask readback");
      apb(1'b0, 8'h20, 32'h0);
      check(err === 1'b1 && q === 32'h0, "unmapped");
      wait_lock(1'b0);
      check(lk_oe === 1'b1 && w_oe === 1'b1 && irq === 1'b1, "lock");
      $display("test regs done");
   endtask
   task t_data;
      int e;
      for (e = 0; e < 2; e++) begin
         es <= e[0];
         tx <= e[0] ? 10'h2B4 : 10'h0E1;
         repeat (4) grab();
         check(got === tx, "word on strobe");
      end
      apb(1'b0, sdoc_pkg::ADDR_WORD, 32'h0);
      check(q[9:0] === tx, "word register");
      apb(1'b1, sdoc_pkg::ADDR_IRQ_MASK, 32'h0);
      check(irq === 1'b0, "masked irq");
      apb(1'b1, sdoc_pkg::ADDR_IRQ_STAT, 32'h7);
      apb(1'b1, sdoc_pkg::ADDR_IRQ_MASK, 32'h7);
      check(irq === 1'b0, "cleared irq");
      $display("test data done");
   endtask
   task t_faults;
      tx <= 10'h3FF;
      corrupt <= 1'b1;
      wait_lock(1'b1);
      corrupt <= 1'b0;
      check(w_oe === 1'b0 && rc_oe === 1'b0, "float unlocked");
      apb(1'b0, sdoc_pkg::ADDR_IRQ_STAT, 32'h0);
      check(q[sdoc_pkg::IRQ_LOST] === 1'b1 && irq === 1'b1, "lost event");
      wait_lock(1'b0);
      ren <= 1'b0;
      repeat (5) @(posedge pclk);
      check(w_oe === 1'b0 && rc_oe === 1'b0 && lk === 1'b0, "disable");
      ren <= 1'b1;
      sl_n <= 1'b0;
      repeat (5) @(posedge pclk);
      check(lk_oe === 1'b0 && w_oe === 1'b0 && lk === 1'b1, "sleep");
      sl_n <= 1'b1;
      wait_lock(1'b0);
      $display("test faults done");
   endtask
   task t_ctrl;
      apb(1'b0, sdoc_pkg::ADDR_STATUS, 32'h0);
      check((q & 32'hFFFFFFFB) === 32'h00000039 && err === 1'b0, "status");
      apb(1'b1, sdoc_pkg::ADDR_CTRL, 32'h2);
      check(w_oe === 1'b0 && rc_oe === 1'b0 && lk === 1'b0, "soft off");
      apb(1'b1, sdoc_pkg::ADDR_CTRL, 32'h1);
      check(lk_oe === 1'b0 && w_oe === 1'b0 && lk === 1'b1, "soft nap");
      apb(1'b0, sdoc_pkg::ADDR_CTRL, 32'h0);
      check(q === 32'h1, "ctrl readback");
      apb(1'b1, sdoc_pkg::ADDR_CTRL, 32'h0);
      wait_lock(1'b0);
      ce <= 1'b0;
      @(posedge pclk);
      snap = word;
      snap_rc = rc;
      apb(1'b1, sdoc_pkg::ADDR_IRQ_MASK, 32'h0);
      repeat (100) @(posedge pclk);
      check(word === snap && rc === snap_rc && lk === 1'b0, "ce freeze");
      ce <= 1'b1;
      apb(1'b0, sdoc_pkg::ADDR_IRQ_MASK, 32'h0);
      check(q === 32'h7, "ce drops write");
      $display("test ctrl done");
   endtask
   task t_reset;
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      check(lk === 1'b1 && lk_oe === 1'b0 && w_oe === 1'b0, "reset pins");
      check(word === 10'h000 && rc === 1'b0 && irq === 1'b0, "reset vals");
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, sdoc_pkg::ADDR_IRQ_MASK, 32'h0);
      check(q === 32'h0, "mask reset");
      wait_lock(1'b0);
      check(irq === 1'b0 && lk_oe === 1'b1, "relock masked");
      apb(1'b0, sdoc_pkg::ADDR_IRQ_STAT, 32'h0);
      check(q[sdoc_pkg::IRQ_LOCK] === 1'b1, "lock event");
      $display("test reset done");
   endtask
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_data();
      t_faults();
      t_ctrl();
      t_reset();
      stop_test();
   end
endmodule
